// ==== rtl/oic_pkg.sv ====
package oic_pkg;
   // register map
   localparam logic [7:0] OIC_CFG_ADDR      = 8'hCB;
   localparam logic [7:0] OIC_MASK_ADDR     = 8'hCC;
   localparam logic [7:0] OIC_CFG_RESET     = 8'h23;
   localparam logic [7:0] OIC_MASK_RESET    = 8'hA0;
   localparam logic [7:0] OIC_CFG_RW_MASK   = 8'h7F;
   localparam logic [7:0] OIC_MASK_RW_MASK  = 8'hDF;
   // serial output config fields
   localparam int OIC_AMP_LSB    = 0;
   localparam int OIC_AMP_W      = 4;
   localparam int OIC_DIV_INV    = 4;
   localparam int OIC_DIV_EN     = 5;
   localparam int OIC_SWING_HI   = 6;
   localparam logic [3:0] OIC_AMP_MIN_60MV   = 4'h0;
   localparam logic [3:0] OIC_AMP_DEF_250MV  = 4'h3;
   localparam logic [3:0] OIC_AMP_MAX_1000MV = 4'hF;
   // interrupt mask fields
   localparam int OIC_SRC_W      = 5;
   localparam int OIC_SRC_TEMP   = 4;
   localparam int OIC_IRQ_INV    = 6;
   localparam int OIC_IRQ_PP     = 7;
   // strap decode
   localparam logic [31:0] OIC_TELECOM_FRAME = 32'hF6F62828;
   localparam logic [4:0]  OIC_DEMUX_16 = 5'h10;
   localparam logic [4:0]  OIC_DEMUX_10 = 5'h0A;
   localparam logic [4:0]  OIC_DEMUX_8  = 5'h08;
   localparam logic [4:0]  OIC_DEMUX_4  = 5'h04;
   localparam logic [9:0]  OIC_NET_COMMA = 10'h0FA;
   typedef enum logic [2:0] {
      OIC_RATE_155M, OIC_RATE_622M, OIC_RATE_2G5, OIC_RATE_2G5_FEC,
      OIC_RATE_FC, OIC_RATE_2FC, OIC_RATE_GE, OIC_RATE_10GE
   } oic_rate_t;
   localparam logic [7:0] OIC_UNMAPPED_READ = 8'h00;
endpackage

// ==== rtl/oic_config.sv ====
`timescale 1ns/1ns
`default_nettype none
module oic_config #(
   parameter logic [6:0] DEV_ADDR = 7'h3A // arbitrary bus address
) (
   input  wire logic                     sys_clk,
   input  wire logic                     rst,
   input  wire logic                     scl_in,
   input  wire logic                     sda_in,
   output logic                          sda_out,
   output logic                          sda_oe_n,
   input  wire logic                     host_interface_select,
   input  wire logic [2:0]               rate_select_pins,
   input  wire logic                     demux_ratio_hi_pin,
   input  wire logic                     demux_ratio_lo_pin,
   input  wire logic                     byte_align_enable_pin,
   input  wire logic                     loop_in_enable_n,
   input  wire logic                     loop_out_enable_n,
   input  wire logic                     channel_select_pin,
   input  wire logic                     freq_window_pin,
   input  wire logic                     ch1_threshold_pin,
   input  wire logic                     ch2_threshold_pin,
   input  wire logic                     signal_loss_ch1,
   input  wire logic                     signal_loss_ch2,
   input  wire logic                     freq_in_window,
   input  wire logic                     limiter_select_event,
   input  wire logic                     temp_alarm,
   input  wire logic                     divider_in,
   output logic [3:0]                    serial_out_amplitude,
   output logic                          divider_out_invert,
   output logic                          divider_out_enable,
   output logic                          serial_out_swing_high,
   output logic                          divider_output,
   output logic                          irq_out,
   output logic                          irq_oe_n,
   output logic                          strap_mode,
   output oic_pkg::oic_rate_t            line_rate,
   output logic                          rate_is_telecom,
   output logic [4:0]                    demux_ratio,
   output logic [31:0]                   frame_pattern,
   output logic [9:0]                    net_comma,
   output logic                          byte_align_en,
   output logic                          loop_in_path_en,
   output logic                          loop_out_path_en,
   output logic                          freq_window_1000ppm,
   output logic                          ch1_detector_en,
   output logic                          ch2_detector_en,
   output logic                          ch1_active
);
   import oic_pkg::*;
   typedef enum logic [3:0] {
      ST_IDLE, ST_ADDR, ST_ACK_ADDR, ST_SUB, ST_ACK_SUB,
      ST_WR, ST_ACK_WR, ST_RD, ST_RD_ACK
   } oic_state_t;
   oic_state_t  state_reg;
   logic        scl_prev_reg;
   logic        sda_prev_reg;
   logic [3:0]  bit_cnt_reg;
   logic [7:0]  shift_reg;
   logic [7:0]  ptr_reg;
   logic [7:0]  tx_reg;
   logic        rw_reg;
   logic        master_ack_reg;
   logic        sda_oe_n_reg;
   logic        wr_en;
   logic [7:0]  cfg_reg;
   logic [7:0]  mask_reg;
   logic        scl_rise;
   logic        scl_fall;
   logic        bus_start;
   logic        bus_stop;
   logic        byte_done;
   logic [OIC_SRC_W-1:0] sources;
   logic        irq_active;
   logic        irq_level;
   logic        irq_pp;

   function automatic logic [7:0] read_reg(input logic [7:0] addr,
                                           input logic [7:0] cfg,
                                           input logic [7:0] msk);
      logic [7:0] val;
      val = OIC_UNMAPPED_READ;
      if (addr == OIC_CFG_ADDR) begin
         val = cfg & OIC_CFG_RW_MASK;
      end else if (addr == OIC_MASK_ADDR) begin
         val = msk & OIC_MASK_RW_MASK;
      end
      return val;
   endfunction
   // bus line events
   assign scl_rise  = scl_in & ~scl_prev_reg;
   assign scl_fall  = ~scl_in & scl_prev_reg;
   assign bus_start = scl_in & scl_prev_reg & sda_prev_reg & ~sda_in;
   assign bus_stop  = scl_in & scl_prev_reg & ~sda_prev_reg & sda_in;
   assign byte_done = scl_fall && (bit_cnt_reg == 4'h8);
   assign wr_en     = (state_reg == ST_WR) && byte_done;
   assign sda_out   = 1'b0;
   assign sda_oe_n  = sda_oe_n_reg;

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         scl_prev_reg <= 1'b1;
         sda_prev_reg <= 1'b1;
      end else begin
         scl_prev_reg <= scl_in;
         sda_prev_reg <= sda_in;
      end
   end

   // serial bus slave: address, sub-address, data with auto-increment
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         state_reg      <= ST_IDLE;
         bit_cnt_reg    <= 4'h0;
         shift_reg      <= 8'h00;
         ptr_reg        <= 8'h00;
         tx_reg         <= 8'h00;
         rw_reg         <= 1'b0;
         master_ack_reg <= 1'b1;
         sda_oe_n_reg   <= 1'b1;
      end else if (bus_start) begin
         state_reg    <= ST_ADDR;
         bit_cnt_reg  <= 4'h0;
         sda_oe_n_reg <= 1'b1;
      end else if (bus_stop) begin
         state_reg    <= ST_IDLE;
         sda_oe_n_reg <= 1'b1;
      end else begin
         unique case (state_reg)
            ST_IDLE: sda_oe_n_reg <= 1'b1;
            ST_ADDR, ST_SUB, ST_WR: begin
               if (scl_rise) begin
                  shift_reg   <= {shift_reg[6:0], sda_in};
                  bit_cnt_reg <= bit_cnt_reg + 4'h1;
               end else if (byte_done) begin
                  bit_cnt_reg  <= 4'h0;
                  sda_oe_n_reg <= 1'b0;
                  if (state_reg == ST_ADDR) begin
                     if (shift_reg[7:1] == DEV_ADDR) begin
                        rw_reg    <= shift_reg[0];
                        state_reg <= ST_ACK_ADDR;
                     end else begin
                        sda_oe_n_reg <= 1'b1;
                        state_reg    <= ST_IDLE;
                     end
                  end else if (state_reg == ST_SUB) begin
                     ptr_reg   <= shift_reg;
                     state_reg <= ST_ACK_SUB;
                  end else begin
                     state_reg <= ST_ACK_WR;
                  end
               end
            end
            ST_ACK_ADDR: begin
               if (scl_fall) begin
                  if (rw_reg) begin
                     tx_reg       <= read_reg(ptr_reg, cfg_reg, mask_reg);
                     sda_oe_n_reg <= read_reg(ptr_reg, cfg_reg, mask_reg) >> 7 == 8'h01;
                     bit_cnt_reg  <= 4'h0;
                     state_reg    <= ST_RD;
                  end else begin
                     sda_oe_n_reg <= 1'b1;
                     state_reg    <= ST_SUB;
                  end
               end
            end
            ST_ACK_SUB, ST_ACK_WR: begin
               if (scl_fall) begin
                  sda_oe_n_reg <= 1'b1;
                  state_reg    <= ST_WR;
                  if (state_reg == ST_ACK_WR) begin
                     ptr_reg <= ptr_reg + 8'h01;
                  end
               end
            end
            ST_RD: begin
               if (scl_rise) begin
                  bit_cnt_reg <= bit_cnt_reg + 4'h1;
                  tx_reg      <= {tx_reg[6:0], 1'b0};
               end else if (byte_done) begin
                  sda_oe_n_reg <= 1'b1;
                  state_reg    <= ST_RD_ACK;
               end else if (scl_fall) begin
                  sda_oe_n_reg <= tx_reg[7];
               end
            end
            ST_RD_ACK: begin
               if (scl_rise) begin
                  master_ack_reg <= sda_in;
               end else if (scl_fall) begin
                  if (!master_ack_reg) begin
                     ptr_reg      <= ptr_reg + 8'h01;
                     tx_reg       <= read_reg(ptr_reg + 8'h01, cfg_reg, mask_reg);
                     sda_oe_n_reg <= read_reg(ptr_reg + 8'h01, cfg_reg, mask_reg) >> 7 == 8'h01;
                     bit_cnt_reg  <= 4'h0;
                     state_reg    <= ST_RD;
                  end else begin
                     state_reg <= ST_IDLE;
                  end
               end
            end
         endcase
      end
   end

   // serial output configuration register
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         cfg_reg <= OIC_CFG_RESET;
      end else if (wr_en && ptr_reg == OIC_CFG_ADDR) begin
         cfg_reg <= shift_reg & OIC_CFG_RW_MASK;
      end
   end

   // interrupt mask register
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         mask_reg <= OIC_MASK_RESET;
      end else if (wr_en && ptr_reg == OIC_MASK_ADDR) begin
         mask_reg <= shift_reg & OIC_MASK_RW_MASK;
      end
   end

   // register-driven analog controls and the divider output
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         serial_out_amplitude  <= OIC_AMP_DEF_250MV;
         divider_out_invert    <= 1'b0;
         divider_out_enable    <= 1'b0;
         serial_out_swing_high <= 1'b0;
         divider_output        <= 1'b0;
      end else begin
         serial_out_amplitude  <= cfg_reg[OIC_AMP_LSB +: OIC_AMP_W];
         divider_out_invert    <= cfg_reg[OIC_DIV_INV];
         divider_out_enable    <= cfg_reg[OIC_DIV_EN];
         serial_out_swing_high <= cfg_reg[OIC_SWING_HI];
         divider_output        <= cfg_reg[OIC_DIV_EN]
                                  & (divider_in ^ cfg_reg[OIC_DIV_INV]);
      end
   end

   // interrupt pin: host mode uses mask register, strap mode temp alarm only
   assign sources    = {temp_alarm, limiter_select_event, freq_in_window,
                        signal_loss_ch2, signal_loss_ch1};
   assign irq_active = strap_mode ? temp_alarm
                                  : |(sources & mask_reg[OIC_SRC_W-1:0]);
   assign irq_level  = irq_active ^ (~strap_mode & mask_reg[OIC_IRQ_INV]);
   assign irq_pp     = ~strap_mode & mask_reg[OIC_IRQ_PP];

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         irq_out  <= 1'b0;
         irq_oe_n <= 1'b1;
      end else begin
         irq_out  <= irq_pp & irq_level;
         irq_oe_n <= irq_pp ? 1'b0 : irq_level;
      end
   end

   // strap decode, taken every cycle while interface select is low
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         strap_mode          <= 1'b0;
         line_rate           <= OIC_RATE_2G5;
         rate_is_telecom     <= 1'b1;
         demux_ratio         <= OIC_DEMUX_16;
         frame_pattern       <= OIC_TELECOM_FRAME;
         net_comma           <= OIC_NET_COMMA;
         byte_align_en       <= 1'b0;
         loop_in_path_en     <= 1'b0;
         loop_out_path_en    <= 1'b0;
         freq_window_1000ppm <= 1'b1;
         ch1_detector_en     <= 1'b0;
         ch2_detector_en     <= 1'b0;
         ch1_active          <= 1'b1;
      end else begin
         strap_mode <= ~host_interface_select;
         if (!host_interface_select) begin
            line_rate       <= oic_rate_t'(rate_select_pins);
            rate_is_telecom <= ~rate_select_pins[2];
            unique case ({demux_ratio_hi_pin, demux_ratio_lo_pin})
               2'b11: demux_ratio <= OIC_DEMUX_16;
               2'b10: demux_ratio <= OIC_DEMUX_10;
               2'b01: demux_ratio <= OIC_DEMUX_8;
               2'b00: demux_ratio <= OIC_DEMUX_4;
            endcase
            frame_pattern       <= OIC_TELECOM_FRAME;
            net_comma           <= OIC_NET_COMMA;
            byte_align_en       <= byte_align_enable_pin;
            loop_in_path_en     <= ~loop_in_enable_n;
            loop_out_path_en    <= ~loop_out_enable_n;
            freq_window_1000ppm <= freq_window_pin;
            ch1_detector_en     <= ch1_threshold_pin;
            ch2_detector_en     <= ch2_threshold_pin;
            ch1_active          <= channel_select_pin;
         end
      end
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   sequence wr_byte_end_s;
      (state_reg == ST_WR) && byte_done;
   endsequence
   sequence ack_driven_s;
      (state_reg == ST_ACK_WR) && !sda_oe_n_reg;
   endsequence
   cfg_reserved_a: assert property (cfg_reg[7] == 1'b0)
      else $error("reserved config bit set");
   mask_reserved_a: assert property ((read_reg(OIC_MASK_ADDR, cfg_reg, mask_reg)
      & ~OIC_MASK_RW_MASK) == 8'h00) else $error("reserved mask bit reads set");
   cfg_write_a: assert property (wr_byte_end_s and (ptr_reg == OIC_CFG_ADDR)
      |=> cfg_reg == ($past(shift_reg) & OIC_CFG_RW_MASK))
      else $error("config write not stored");
   write_ack_a: assert property (wr_byte_end_s |=> ack_driven_s)
      else $error("data byte not acknowledged");
   divider_out_a: assert property (!cfg_reg[OIC_DIV_EN] |=> !divider_output)
      else $error("disabled divider output active");
   irq_mask_a: assert property (!strap_mode && mask_reg[OIC_IRQ_PP]
      && !mask_reg[OIC_IRQ_INV] && (sources & mask_reg[4:0]) == 5'h00 |=> !irq_out && !irq_oe_n)
      else $error("masked source reached interrupt pin");
   irq_assert_a: assert property (!strap_mode && mask_reg[OIC_IRQ_PP]
      && (sources & mask_reg[4:0]) != 5'h00 |=> irq_out == !$past(mask_reg[6]))
      else $error("interrupt pin wrong level");
   irq_drain_a: assert property (!mask_reg[OIC_IRQ_PP] |=> !irq_out)
      else $error("open-drain pin driven high");
   strap_alarm_a: assert property (strap_mode && temp_alarm |=> irq_oe_n && !irq_out)
      else $error("temperature alarm not reported");
   loop_out_a: assert property (!host_interface_select && loop_out_enable_n
      |=> !loop_out_path_en)
      else $error("loop outputs not disabled");
   demux_16_a: assert property (!host_interface_select && demux_ratio_hi_pin
      && demux_ratio_lo_pin |=> demux_ratio == OIC_DEMUX_16)
      else $error("ratio straps not decoded to 16");
   chan_sel_a: assert property (!host_interface_select && channel_select_pin
      |=> ch1_active)
      else $error("channel 1 not selected");
   rate_2g5_a: assert property (!host_interface_select && rate_select_pins == 3'b010
      |=> line_rate == OIC_RATE_2G5 && rate_is_telecom)
      else $error("rate code not decoded");
endmodule // oic_config
`default_nettype wire

// ==== bench/oic_host.sv ====
`timescale 1ns/1ns
`default_nettype none
module oic_host (
   input  wire logic sys_clk,
   input  wire logic sda_line,
   output logic      scl,
   output logic      sda_drv
);
   initial begin
      scl = 1'b1;
      sda_drv = 1'b1;
   end
   // quarter of a bus bit: 4 system cycles, moves just after the edge
   task automatic q();
      repeat (4) @(posedge sys_clk);
      #5;
   endtask
   // start, or repeated start when scl is already low
   task automatic start();
      sda_drv = 1'b1;
      q();
      scl = 1'b1;
      q();
      sda_drv = 1'b0;
      q();
      scl = 1'b0;
      q();
   endtask
   task automatic stop();
      sda_drv = 1'b0;
      q();
      scl = 1'b1;
      q();
      sda_drv = 1'b1;
      q();
   endtask
   // data only changes while scl is low, sampled mid high phase
   task automatic bit_io(input logic b, output logic r);
      sda_drv = b;
      q();
      scl = 1'b1;
      q();
      r = sda_line;
      q();
      scl = 1'b0;
      q();
   endtask
   // v = FF releases the line to receive; last is the ninth bit sent
   task automatic byte_io(input logic [7:0] v, input logic last,
                          output logic [7:0] r, output logic ack);
      logic t;
      for (int i = 7; i >= 0; i--) begin
         bit_io(v[i], t);
         r[i] = t;
      end
      bit_io(last, ack);
   endtask
   // whole bytes only, sub then two data bytes
   task automatic wr(input logic [6:0] dev, input logic [7:0] sub, input logic [7:0] d0,
                     input logic [7:0] d1, output logic [3:0] acks);
      logic [7:0] r;
      start();
      byte_io({dev, 1'b0}, 1'b1, r, acks[3]);
      byte_io(sub, 1'b1, r, acks[2]);
      byte_io(d0, 1'b1, r, acks[1]);
      byte_io(d1, 1'b1, r, acks[0]);
      stop();
   endtask
   task automatic rd(input logic [6:0] dev, input logic [7:0] sub, output logic [7:0] d0,
                     output logic [7:0] d1, output logic [2:0] acks);
      logic n;
      start();
      byte_io({dev, 1'b0}, 1'b1, d0, acks[2]);
      byte_io(sub, 1'b1, d0, acks[1]);
      start();
      byte_io({dev, 1'b1}, 1'b1, d0, acks[0]);
      byte_io(8'hFF, 1'b0, d0, n);
      byte_io(8'hFF, 1'b1, d1, n);
      stop();
   endtask
endmodule // oic_host
`default_nettype wire

// ==== bench/tb.sv ====
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin err_count++; \
   $display("ERROR t=%0t got %h exp %h", $time, (a), (e)); end end
module tb;
   import oic_pkg::*;
   localparam logic [6:0] DEV = 7'h3A;
   logic sys_clk = 1'b0, rst = 1'b1, host_interface_select = 1'b1, divider_in = 1'b0;
   logic [2:0] rate_select_pins = 3'h0;
   logic [4:0] src = 5'h00;
   logic demux_ratio_hi_pin = 1'b0, demux_ratio_lo_pin = 1'b0, byte_align_enable_pin = 1'b0;
   logic loop_in_enable_n = 1'b1, loop_out_enable_n = 1'b1, channel_select_pin = 1'b0;
   logic freq_window_pin = 1'b0, ch1_threshold_pin = 1'b0, ch2_threshold_pin = 1'b0;
   logic scl_in, host_sda, sda_line, sda_out, sda_oe_n, divider_output, irq_out, irq_oe_n;
   logic [3:0] serial_out_amplitude, a;
   logic divider_out_invert, divider_out_enable, serial_out_swing_high, strap_mode;
   logic rate_is_telecom, byte_align_en, loop_in_path_en, loop_out_path_en;
   logic freq_window_1000ppm, ch1_detector_en, ch2_detector_en, ch1_active;
   oic_rate_t line_rate;
   logic [4:0] demux_ratio;
   logic [31:0] frame_pattern;
   logic [9:0] net_comma;
   logic [7:0] c, m, d0, d1;
   logic [7:0] cv [4] = '{8'h00, 8'h0F, 8'hFF, 8'h73};
   logic [7:0] mv [4] = '{8'hA0, 8'h1F, 8'hDF, 8'h40};
   integer seed, err_count = 0, cmp_count = 0;

   // released open-drain line floats high through the pull-up
   assign sda_line = host_sda & (sda_oe_n | sda_out);
   always #50 sys_clk = ~sys_clk;

   oic_host host (.sys_clk, .sda_line, .scl(scl_in), .sda_drv(host_sda));
   oic_config #(.DEV_ADDR(DEV)) dut (
      .sys_clk, .rst, .scl_in, .sda_in(sda_line), .sda_out, .sda_oe_n,
      .host_interface_select, .rate_select_pins, .demux_ratio_hi_pin, .demux_ratio_lo_pin,
      .byte_align_enable_pin, .loop_in_enable_n, .loop_out_enable_n, .channel_select_pin,
      .freq_window_pin, .ch1_threshold_pin, .ch2_threshold_pin,
      .signal_loss_ch1(src[0]), .signal_loss_ch2(src[1]), .freq_in_window(src[2]),
      .limiter_select_event(src[3]), .temp_alarm(src[4]), .divider_in,
      .serial_out_amplitude, .divider_out_invert, .divider_out_enable, .serial_out_swing_high,
      .divider_output, .irq_out, .irq_oe_n, .strap_mode, .line_rate, .rate_is_telecom,
      .demux_ratio, .frame_pattern, .net_comma, .byte_align_en, .loop_in_path_en,
      .loop_out_path_en, .freq_window_1000ppm, .ch1_detector_en, .ch2_detector_en, .ch1_active
   );

   // {irq_out, irq_oe_n} from the active sources, polarity and drive mode
   function automatic logic [1:0] exp_irq(input logic [4:0] s, input logic inv, input logic pp);
      logic lv;
      lv = (|s) ^ inv;
      return pp ? {lv, 1'b0} : {1'b0, lv};
   endfunction
   function automatic logic [4:0] exp_dmx(input logic [1:0] s);
      return s == 2'b11 ? OIC_DEMUX_16 : s == 2'b10 ? OIC_DEMUX_10 :
             s == 2'b01 ? OIC_DEMUX_8 : OIC_DEMUX_4;
   endfunction
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
      #5;
   endtask
   task automatic rnd_pins();
      {demux_ratio_lo_pin, byte_align_enable_pin, loop_in_enable_n, loop_out_enable_n,
       channel_select_pin, freq_window_pin, ch1_threshold_pin} = 7'($random(seed));
      {ch2_threshold_pin, divider_in, src} = 7'($random(seed));
   endtask
   task automatic print_verdict();
      if (err_count == 0 && cmp_count > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask

   initial begin
      #6000000;
      err_count++;
      print_verdict();
   end

   initial begin
      seed = 32'h6c74fa75;
      tick(16);
      rst = 1'b0;
      tick(2);
      `CHK(serial_out_amplitude, OIC_AMP_DEF_250MV)
      `CHK({serial_out_swing_high, divider_out_enable, divider_out_invert}, 3'b010)
      `CHK({irq_out, irq_oe_n}, 2'b00)
      host.rd(DEV, OIC_CFG_ADDR, d0, d1, a[2:0]);
      `CHK({a[2:0], d0, d1}, {3'b000, OIC_CFG_RESET, OIC_MASK_RESET & OIC_MASK_RW_MASK})
      rate_select_pins = 3'h5;
      demux_ratio_hi_pin = 1'b0;
      rnd_pins();
      tick(3);
      `CHK({strap_mode, line_rate, demux_ratio}, {1'b0, OIC_RATE_2G5, OIC_DEMUX_16})
      for (int i = 0; i < 12; i++) begin
         c = (i < 4) ? cv[i] : 8'($random(seed));
         m = (i < 4) ? mv[i] : 8'($random(seed));
         host.wr(DEV, OIC_CFG_ADDR, c, m, a);
         `CHK(a, 4'h0)
         host.rd(DEV, OIC_CFG_ADDR, d0, d1, a[2:0]);
         `CHK({d0, d1}, {c & 8'h7F, m & 8'hDF})
         `CHK(serial_out_amplitude, c[3:0])
         `CHK({serial_out_swing_high, divider_out_enable, divider_out_invert}, c[6:4])
         for (int k = 0; k < 4; k++) begin
            rnd_pins();
            tick(2);
            `CHK({irq_out, irq_oe_n}, exp_irq(src & m[4:0], m[6], m[7]))
            `CHK(divider_output, c[5] & (divider_in ^ c[4]))
         end
      end
      // wrong address: no acknowledge, nothing changes
      host.wr(DEV ^ 7'h01, OIC_CFG_ADDR, 8'h11, 8'h11, a);
      `CHK(a, 4'hF)
      // unmapped byte ignored, pointer still steps to the config register
      host.wr(DEV, 8'hCA, 8'h5A, 8'h55, a);
      host.rd(DEV, OIC_CFG_ADDR, d0, d1, a[2:0]);
      `CHK({d0, d1}, {8'h55, m & 8'hDF})
      host.rd(DEV, 8'hCD, d0, d1, a[2:0]);
      `CHK({d0, d1}, {OIC_UNMAPPED_READ, OIC_UNMAPPED_READ})
      host_interface_select = 1'b0;
      for (int i = 0; i < 16; i++) begin
         rate_select_pins = 3'(i);
         demux_ratio_hi_pin = i[3];
         rnd_pins();
         tick(2);
         `CHK({strap_mode, line_rate, rate_is_telecom}, {1'b1, 3'(i), ~i[2]})
         `CHK(demux_ratio, exp_dmx({demux_ratio_hi_pin, demux_ratio_lo_pin}))
         `CHK(frame_pattern, OIC_TELECOM_FRAME)
         `CHK(net_comma, OIC_NET_COMMA)
         `CHK(byte_align_en, byte_align_enable_pin)
         `CHK(loop_in_path_en, ~loop_in_enable_n)
         `CHK(loop_out_path_en, ~loop_out_enable_n)
         `CHK(freq_window_1000ppm, freq_window_pin)
         `CHK({irq_out, irq_oe_n}, exp_irq({src[4], 4'h0}, 1'b0, 1'b0))
         `CHK({ch1_detector_en, ch2_detector_en}, {ch1_threshold_pin, ch2_threshold_pin})
         `CHK(ch1_active, channel_select_pin)
      end
      host_interface_select = 1'b1;
      rst = 1'b1;
      tick(2);
      rst = 1'b0;
      tick(2);
      `CHK({strap_mode, serial_out_amplitude}, {1'b0, OIC_AMP_DEF_250MV})
      `CHK({line_rate, demux_ratio, ch1_active}, {OIC_RATE_2G5, OIC_DEMUX_16, 1'b1})
      print_verdict();
   end
endmodule // tb
`default_nettype wire
